//--- core/fbd_host.sv
// Host controller driving a dual-select parallel NOR flash
// Function
// - Non-read functions are started by writing command cycles.
// - After an undefined state the reset command is to be issued; this host pulls hw_clear_n low instead, at reset and on FBD_OP_RESET.
// - Reads use select low, gate low, strobe high; writes the reverse.
// - The guard is high while writing sectors 0, 1, 68 and 69.
// - Each half is addressed with its own select and 22-bit address.
// - Exactly one select is low during a read or write.
`timescale 1ns/1ps
`default_nettype none
module fbd_host (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Request
    input wire logic req_valid_in,
    input wire fbd_pkg::fbd_req_t req_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic [15:0] rsp_data_out,
    // Flash pins
    output fbd_pkg::fbd_ctl_t ctl_out,
    output logic [21:0] addr_out,
    output logic [15:0] dq_out,
    output logic dq_oe_out,
    input wire logic [15:0] dq_in
);
    import fbd_pkg::*;

    typedef enum logic [2:0] {
        FBD_IDLE = 3'b000,
        FBD_SETUP = 3'b001,
        FBD_PULSE = 3'b010,
        FBD_HOLD = 3'b011,
        FBD_CLEAR = 3'b100
    } fbd_state_t;

    fbd_state_t state_ff, nxt_state;
    fbd_req_t req_ff, nxt_req;
    fbd_ctl_t ctl_ff, nxt_ctl;
    logic [3:0] cnt_ff, nxt_cnt;
    logic [21:0] addr_ff, nxt_addr;
    logic [15:0] dq_ff, nxt_dq;
    logic oe_ff, nxt_oe;
    logic rdy_ff, nxt_rdy;
    logic rv_ff, nxt_rv;
    logic [15:0] rd_ff, nxt_rd;
    logic [15:0] dq_s1_ff, dq_s2_ff;
    logic [6:0] sector;

    function automatic logic guarded(input logic [6:0] s);
        guarded = (s == FBD_SEC_LO0) || (s == FBD_SEC_LO1) ||
            (s == FBD_SEC_HI0) || (s == FBD_SEC_HI1);
    endfunction

    function automatic fbd_ctl_t idle_ctl();
        fbd_ctl_t c;
        c = '{lower_half_select_n: 1'b1, upper_half_select_n: 1'b1,
            out_gate_n: 1'b1, write_strobe_n: 1'b1, hw_clear_n: 1'b1,
            boot_sector_guard: 1'b0};
        idle_ctl = c;
    endfunction

    fbd_sector_map u_map (
        .upper_half_in(req_ff.upper_half),
        .addr_in(req_ff.addr),
        .sector_out(sector)
    );

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            dq_s1_ff <= 16'h0000;
            dq_s2_ff <= 16'h0000;
        end else begin
            dq_s1_ff <= dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_ctl = ctl_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_dq = dq_ff;
        nxt_oe = oe_ff;
        nxt_rdy = 1'b0;
        nxt_rv = 1'b0;
        nxt_rd = rd_ff;
        case (state_ff)
            FBD_IDLE: begin
                nxt_ctl = idle_ctl();
                nxt_oe = 1'b0;
                nxt_rdy = 1'b1;
                if (req_valid_in && rdy_ff) begin
                    nxt_rdy = 1'b0;
                    nxt_req = req_in;
                    nxt_cnt = FBD_SETUP_CYC;
                    if (req_in.op == FBD_OP_RESET) begin
                        // Pulse clear, device returns to read mode
                        nxt_ctl.hw_clear_n = 1'b0;
                        nxt_state = FBD_CLEAR;
                        nxt_cnt = FBD_PULSE_CYC;
                    end else begin
                        nxt_ctl.lower_half_select_n = req_in.upper_half;
                        nxt_ctl.upper_half_select_n = !req_in.upper_half;
                        nxt_addr = req_in.addr;
                        nxt_state = FBD_SETUP;
                    end
                end
            end
            FBD_SETUP: begin
                nxt_cnt = 4'(cnt_ff - 4'h1);
                if (req_ff.op == FBD_OP_WRITE) begin
                    nxt_ctl.boot_sector_guard = guarded(sector);
                    nxt_dq = req_ff.data;
                    nxt_oe = 1'b1;
                end
                if (cnt_ff == 4'h1) begin
                    nxt_cnt = FBD_PULSE_CYC;
                    nxt_state = FBD_PULSE;
                    // Only one of gate and strobe falls
                    // Strobe falls after select and address
                    if (req_ff.op == FBD_OP_WRITE) begin
                        nxt_ctl.write_strobe_n = 1'b0;
                    end else begin
                        nxt_ctl.out_gate_n = 1'b0;
                    end
                end
            end
            FBD_PULSE: begin
                nxt_cnt = 4'(cnt_ff - 4'h1);
                if (cnt_ff == 4'h1) begin
                    nxt_ctl.write_strobe_n = 1'b1;
                    nxt_ctl.out_gate_n = 1'b1;
                    nxt_cnt = FBD_HOLD_CYC;
                    nxt_state = FBD_HOLD;
                end
            end
            FBD_HOLD: begin
                nxt_cnt = 4'(cnt_ff - 4'h1);
                if (cnt_ff == 4'h1) begin
                    // Read data, taken once through the synchroniser
                    if (req_ff.op == FBD_OP_READ) begin
                        nxt_rd = dq_s2_ff;
                    end
                    nxt_ctl = idle_ctl();
                    nxt_oe = 1'b0;
                    nxt_rv = 1'b1;
                    nxt_state = FBD_IDLE;
                end
            end
            FBD_CLEAR: begin
                nxt_cnt = 4'(cnt_ff - 4'h1);
                if (cnt_ff == 4'h1) begin
                    nxt_ctl = idle_ctl();
                    nxt_rv = 1'b1;
                    nxt_state = FBD_IDLE;
                end
            end
            default: begin
                nxt_state = FBD_IDLE;
                nxt_ctl = idle_ctl();
                nxt_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= FBD_IDLE;
            req_ff <= '0;
            ctl_ff <= '{lower_half_select_n: 1'b1,
                upper_half_select_n: 1'b1, out_gate_n: 1'b1,
                write_strobe_n: 1'b1, hw_clear_n: 1'b0,
                boot_sector_guard: 1'b0};
            cnt_ff <= 4'h0;
            addr_ff <= 22'h00_0000;
            dq_ff <= 16'h0000;
            oe_ff <= 1'b0;
            rdy_ff <= 1'b0;
            rv_ff <= 1'b0;
            rd_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            ctl_ff <= nxt_ctl;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            dq_ff <= nxt_dq;
            oe_ff <= nxt_oe;
            rdy_ff <= nxt_rdy;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
        end
    end

    assign req_ready_out = rdy_ff;
    assign rsp_valid_out = rv_ff;
    assign rsp_data_out = rd_ff;
    assign ctl_out = ctl_ff;
    assign addr_out = addr_ff;
    assign dq_out = dq_ff;
    assign dq_oe_out = oe_ff;
endmodule // fbd_host
`default_nettype wire

//--- pkg/fbd_pkg.sv
// Package for the parallel flash bus host controller
package fbd_pkg;
    localparam int unsigned FBD_ADDR_W = 22;
    localparam int unsigned FBD_DATA_W = 16;
    // 100 ns clock; each bus phase lasts at least this many ns
    localparam int unsigned FBD_CLK_NS = 100;
    localparam int unsigned FBD_SETUP_NS = 100;
    localparam int unsigned FBD_PULSE_NS = 200;
    localparam int unsigned FBD_HOLD_NS = 100;
    localparam logic [3:0] FBD_SETUP_CYC =
        4'((FBD_SETUP_NS + FBD_CLK_NS - 1) / FBD_CLK_NS);
    localparam logic [3:0] FBD_PULSE_CYC =
        4'((FBD_PULSE_NS + FBD_CLK_NS - 1) / FBD_CLK_NS);
    localparam logic [3:0] FBD_HOLD_CYC =
        4'((FBD_HOLD_NS + FBD_CLK_NS - 1) / FBD_CLK_NS);
    // Guarded boot sector numbers
    localparam logic [6:0] FBD_SEC_LO0 = 7'h00;
    localparam logic [6:0] FBD_SEC_LO1 = 7'h01;
    localparam logic [6:0] FBD_SEC_HI0 = 7'h44;
    localparam logic [6:0] FBD_SEC_HI1 = 7'h45;
    // Word address of the upper half's 64 KB sectors, lower half's end
    localparam logic [21:0] FBD_SMALL_LO_END = 22'h01_FFFF;
    localparam logic [21:0] FBD_SMALL_HI_BASE = 22'h3E_0000;
    localparam logic [15:0] FBD_RESET_CMD = 16'h00F0;

    typedef enum logic [1:0] {
        FBD_OP_READ = 2'b00,
        FBD_OP_WRITE = 2'b01,
        FBD_OP_RESET = 2'b10
    } fbd_op_t;

    typedef struct packed {
        fbd_op_t op;
        logic upper_half;
        logic [21:0] addr;
        logic [15:0] data;
    } fbd_req_t;

    typedef struct packed {
        logic lower_half_select_n;
        logic upper_half_select_n;
        logic out_gate_n;
        logic write_strobe_n;
        logic hw_clear_n;
        logic boot_sector_guard;
    } fbd_ctl_t;
endpackage : fbd_pkg

//--- core/fbd_sector_map.sv
// Sector number decode for the dual-select address map
`timescale 1ns/1ps
`default_nettype none
module fbd_sector_map (
    // Address
    input wire logic upper_half_in,
    input wire logic [21:0] addr_in,
    // Sector
    output logic [6:0] sector_out
);
    import fbd_pkg::*;
    logic [6:0] big;
    always_comb begin
        // 256 KB sectors are 128K words, so bit 17 upward counts them
        big = 7'(addr_in[21:17]);
        sector_out = 7'h00;
        if (!upper_half_in) begin
            if (addr_in <= FBD_SMALL_LO_END) begin
                sector_out = {5'h00, addr_in[16:15]};
            end else begin
                sector_out = 7'(big + 7'h03);
            end
        end else begin
            if (addr_in >= FBD_SMALL_HI_BASE) begin
                sector_out = 7'(7'h42 + {5'h00, addr_in[16:15]});
            end else begin
                sector_out = 7'(big + 7'h23);
            end
        end
    end
endmodule // fbd_sector_map
`default_nettype wire

//--- dv/fbd_host_props.sv
// Checker for the flash host controller pins
`timescale 1ns/1ps
`default_nettype none
module fbd_host_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // Watched ports
    input wire logic req_valid_in,
    input wire fbd_pkg::fbd_req_t req_in,
    input wire logic req_ready_out,
    input wire logic rsp_valid_out,
    input wire fbd_pkg::fbd_ctl_t ctl_out,
    input wire logic [21:0] addr_out,
    input wire logic dq_oe_out
);
    import fbd_pkg::*;
    logic take, ws, og, ls, us, clr;
    assign take = req_valid_in && req_ready_out;
    assign ws = ctl_out.write_strobe_n;
    assign og = ctl_out.out_gate_n;
    assign ls = ctl_out.lower_half_select_n;
    assign us = ctl_out.upper_half_select_n;
    assign clr = ctl_out.hw_clear_n;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    a_one_select: assert property (ls || us)
        else $error("both selects low");
    a_gate_strobe: assert property (ws || og)
        else $error("gate and strobe low together");
    a_write_pins: assert property (
        !ws |-> (ls != us) && dq_oe_out && clr)
        else $error("strobe without write setup");
    a_read_pins: assert property (!og |-> !dq_oe_out && (ls != us))
        else $error("gate low while driving");
    a_oe_select: assert property (dq_oe_out |-> ls != us)
        else $error("driving with no select");
    a_rw_answer: assert property (take && req_in.op != FBD_OP_RESET
        |-> ##5 rsp_valid_out) else $error("late transfer answer");
    a_clear_answer: assert property (
        take && req_in.op == FBD_OP_RESET
        |=> !clr [*2] ##1 (clr && rsp_valid_out))
        else $error("bad clear pulse");
    a_strobe_width: assert property ($fell(ws) |=> !ws ##1 ws)
        else $error("bad strobe width");
    a_addr_hold: assert property (!ws |-> $stable(addr_out))
        else $error("address moved under strobe");
    a_guard_write: assert property (
        ctl_out.boot_sector_guard |-> dq_oe_out)
        else $error("guard outside write");
    c_read: cover property (take && req_in.op == FBD_OP_READ);
    c_write: cover property (take && req_in.op == FBD_OP_WRITE);
    c_clear: cover property (take && req_in.op == FBD_OP_RESET);
endmodule // fbd_host_props
`default_nettype wire

//--- dv/fbd_flash_model.sv
// Behavioural dual-select flash answering the host pins
`timescale 1ns/1ps
`default_nettype none
module fbd_flash_model (
    // Host pins
    input wire fbd_pkg::fbd_ctl_t ctl_in,
    input wire logic [21:0] addr_in,
    input wire logic [15:0] host_dq_in,
    // Data to host
    output logic [15:0] flash_dq_out
);
    import fbd_pkg::*;
    logic [15:0] mem [logic [22:0]];
    logic [15:0] cmd_latch = '0;
    logic [15:0] last = '0;
    logic [22:0] wa = '0;
    logic ls, us, act, rd, prot;
    assign ls = ctl_in.lower_half_select_n;
    assign us = ctl_in.upper_half_select_n;
    assign act = !(ls && us) && ctl_in.hw_clear_n;
    assign rd = act && ls != us && !ctl_in.out_gate_n &&
        ctl_in.write_strobe_n;
    assign prot = wa[22] ? wa[21:0] >= 22'h3F_0000 : wa[21:0] < 22'h01_0000;
    always @(negedge ctl_in.write_strobe_n)
        if (act) wa = {!us, addr_in};
    always @(posedge ctl_in.write_strobe_n)
        if (act && host_dq_in == FBD_RESET_CMD) cmd_latch = host_dq_in;
        else if (act && (ctl_in.boot_sector_guard || !prot))
            mem[wa] = host_dq_in;
    always @(negedge ctl_in.hw_clear_n) cmd_latch = '0;
    always @(rd, addr_in, us) begin
        if (rd) begin
            flash_dq_out = mem.exists({!us, addr_in}) ? mem[{!us, addr_in}]
                : 16'hFFFF;
            last = flash_dq_out;
        end else
            flash_dq_out = ~last;
    end
endmodule // fbd_flash_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fbd_pkg::*;
    logic clk_in = 0, arst_n_in = 0, req_valid_in = 0;
    fbd_req_t req_in = '0;
    logic req_ready_out, rsp_valid_out, dq_oe_out;
    logic [15:0] rsp_data_out, dq_out, dq_in;
    logic [21:0] addr_out;
    fbd_ctl_t ctl_out;
    int fails = 0, num_checks = 0, cyc = 0;
    logic [15:0] ref_mem [logic [22:0]];
    logic [22:0] edges [6] = '{23'h00_0000, 23'h00_FFFF, 23'h01_0000,
        23'h7E_FFFF, 23'h7F_0000, 23'h7F_FFFF};
    always #50 clk_in = ~clk_in;
    fbd_host dut (.clk_in, .arst_n_in, .req_valid_in, .req_in,
        .req_ready_out, .rsp_valid_out, .rsp_data_out, .ctl_out,
        .addr_out, .dq_out, .dq_oe_out, .dq_in);
    fbd_flash_model flash (.ctl_in(ctl_out), .addr_in(addr_out),
        .host_dq_in(dq_out), .flash_dq_out(dq_in));
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [15:0] got, exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic run(input fbd_op_t op, input logic [22:0] k,
        input logic [15:0] d);
        int n;
        while (req_ready_out !== 1'b1) @(posedge clk_in) #1;
        req_in = '{op: op, upper_half: k[22], addr: k[21:0], data: d};
        req_valid_in = 1;
        @(posedge clk_in) #1;
        req_valid_in = 0;
        n = 0;
        while (rsp_valid_out !== 1'b1 && n < 20) begin
            @(posedge clk_in) #1;
            n++;
        end
        check(16'(rsp_valid_out), 16'h0001);
        check(16'(ctl_out.lower_half_select_n &
            ctl_out.upper_half_select_n), 16'h0001);
        if (op == FBD_OP_WRITE && d != FBD_RESET_CMD) ref_mem[k] = d;
        if (op == FBD_OP_READ)
            check(rsp_data_out,
                ref_mem.exists(k) ? ref_mem[k] : 16'hFFFF);
    endtask
    always @(posedge clk_in) begin
        cyc++;
        if (cyc > 3000) begin
            fails++;
            conclude();
        end
    end
    initial begin
        int i;
        logic [22:0] k;
        i = $urandom(32'h533f_9a98);
        repeat (3) @(posedge clk_in);
        #1 arst_n_in = 1;
        // Array read with no command, then guarded edges in both halves
        foreach (edges[j]) run(FBD_OP_READ, edges[j], 16'h0000);
        foreach (edges[j]) run(FBD_OP_WRITE, edges[j], 16'($urandom));
        foreach (edges[j]) run(FBD_OP_READ, edges[j], 16'h0000);
        // Reset command leaves array data alone
        run(FBD_OP_WRITE, edges[1], FBD_RESET_CMD);
        run(FBD_OP_READ, edges[1], 16'h0000);
        run(FBD_OP_RESET, edges[0], 16'h0000);
        run(FBD_OP_READ, edges[5], 16'h0000);
        for (i = 0; i < 40; i++) begin
            k = {1'($urandom), 3'($urandom), 16'h0000, 3'($urandom)};
            run(fbd_op_t'($urandom % 3), k, 16'($urandom));
        end
        conclude();
    end
endmodule // tb
bind fbd_host fbd_host_props u_props (.clk_in, .arst_n_in, .req_valid_in,
    .req_in, .req_ready_out, .rsp_valid_out, .ctl_out, .addr_out, .dq_oe_out);
`default_nettype wire
